// *** logic/vout_ctrl_defs.vh ***
/*
 * Constants of the output behaviour and detection mask register bank:
 * register addresses, reset values, field positions and the serial
 * slave address.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef VOUT_CTRL_DEFS_VH
`define VOUT_CTRL_DEFS_VH

// Register addresses on the two-wire bus.
`define ADDR_OUT_BEHAV      8'h38
`define ADDR_RSVD_A         8'h39
`define ADDR_RSVD_B         8'h3A
`define ADDR_RSVD_C         8'h3B
`define ADDR_IRQ_MASKS      8'h3C

// Reset values.
`define RST_OUT_BEHAV       8'h2F
`define RST_RSVD_A          8'h55
`define RST_RSVD_B          8'h55
`define RST_RSVD_C          8'h35
`define RST_IRQ_MASKS       8'hFC

// Fields of the output behaviour control register.
`define BIT_REISSUE_EN      7
`define BIT_CLK_TRACK       6
`define BIT_TRANS_BLANK     5
`define BIT_NOVID_BLANK     4
`define GAIN_MSB_HI         3
`define GAIN_MSB_LO         0

// Fields of the mask register: bit of the lowest mask, number of masks.
`define MASK_LSB            2
`define NUM_DETECT          6

// Default 7-bit slave address on the two-wire bus; the value is arbitrary.
`define DEV_ADDR_DEFAULT    7'h44

// Value read back from an address this bank does not hold.
`define READ_UNMAPPED       8'h00

`endif

// *** logic/vout_behaviour.v ***
/*
 * Output behaviour of the pixel port: clock mode, blanking against
 * lock state, vertical blanking pass-through and Cb gain.
 * Assumes lock inputs and Cb samples are synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none

module vout_behaviour (
	input  wire        clk,               // System clock, 40 MHz.
	input  wire        resetn,            // Asynchronous reset, active low.
	input  wire        reissue_en,        // Pass-through control bit.
	input  wire        clk_track_sel,     // Output clock tracks input PLL.
	input  wire        novid_blank_sel,   // Blank when horizontal lock lost, if not tracking.
	input  wire        trans_blank_sel,   // Blank when only horizontal lock, if not tracking.
	input  wire [5:0]  gain,              // Six-bit Cb gain.
	input  wire        horiz_locked,      // Horizontal lock status.
	input  wire        vert_locked,       // Vertical lock status.
	input  wire        vbi_active,        // Vertical blanking interval.
	input  wire [7:0]  cb_in,             // Cb sample, two's complement.
	output reg         out_clk_free_run,  // Output clock free-runs.
	output reg         out_clk_track,     // Output clock follows input PLL.
	output reg         out_blank,         // Output data blanked.
	output reg         fifo_read_en,      // Output FIFO is read.
	output reg         vbi_capture_en,    // Capture and reissue VBI line.
	output reg  [7:0]  cb_out             // Scaled Cb sample.
);

	wire [6:0]         gain_p1;
	wire signed [15:0] cb_prod;
	wire               blank_d;

	// The factor runs from 1/64 at zero up to one at all ones.
	assign gain_p1 = {1'b0, gain} + 7'h01;
	assign cb_prod = $signed(cb_in) * $signed({1'b0, gain_p1});

	// Blanking follows the lock state only while the clock does not track.
	assign blank_d = ~clk_track_sel &
		((~horiz_locked & novid_blank_sel) |
		(horiz_locked & ~vert_locked & trans_blank_sel));

	// All outputs are registered so the pixel port sees clean levels.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_clk_free_run <= 1'b0;
			out_clk_track    <= 1'b0;
			out_blank        <= 1'b0;
			fifo_read_en     <= 1'b0;
			vbi_capture_en   <= 1'b0;
			cb_out           <= 8'h00;
		end else begin
			out_clk_free_run <= ~clk_track_sel & ~horiz_locked;
			out_clk_track    <= clk_track_sel;
			out_blank        <= blank_d;
			fifo_read_en     <= ~blank_d;
			vbi_capture_en   <= reissue_en & vbi_active;
			cb_out           <= cb_prod[13:6];
		end
	end

endmodule // vout_behaviour

`default_nettype wire

// *** logic/vout_ctrl_regs.v ***
/*
 * Register bank for output behaviour, host-writable reserved registers and
 * detection interrupt masks, reached over a two-wire serial slave.
 * Assumes scl and sda are already synchronous to clk and that the
 * board resolves the open-drain sda line from the output enable.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vout_ctrl_defs.vh"

module vout_ctrl_regs #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // Serial slave address.
) (
	input  wire        clk,                 // System clock, 40 MHz.
	input  wire        resetn,              // Asynchronous reset, active low.
	input  wire        scl_in,              // Serial clock level.
	input  wire        sda_in,              // Serial data level.
	output wire        sda_out,             // Serial data drive value.
	output wire        sda_oe_n,            // Serial data drive, active low.
	input  wire [1:0]  cb_gain_lsb,         // Cb gain bits 1:0.
	input  wire        lock_pad_irq_enable, // Lock pad carries interrupt.
	input  wire        lock_pad_func,       // Lock pad alternate function.
	output reg         pll_locked_pad,      // Lock pad level.
	input  wire        nonstd_vsync_status, // Non-standard vsync status.
	input  wire        trick_play_status,   // Trick-play status.
	input  wire        interlace_status,    // Interlaced source status.
	input  wire        tape_source_status,  // Tape source status.
	input  wire        insertion_status,    // Insertion status.
	input  wire        fast_blank_status,   // Fast-blanking status.
	input  wire        horiz_locked,        // Horizontal lock status.
	input  wire        vert_locked,         // Vertical lock status.
	input  wire        vbi_active,          // Vertical blanking interval.
	input  wire [7:0]  cb_in,               // Cb sample in.
	output wire        out_clk_free_run,    // Output clock free-runs.
	output wire        out_clk_track,       // Output clock tracks input PLL.
	output wire        out_blank,           // Output data blanked.
	output wire        fifo_read_en,        // Output FIFO is read.
	output wire        vbi_capture_en,      // VBI line capture and reissue.
	output wire [7:0]  cb_out               // Scaled Cb sample.
);

	// Serial slave states, one-hot.
	localparam [8:0] S_IDLE  = 9'h001;
	localparam [8:0] S_ADDR  = 9'h002;
	localparam [8:0] S_ACKA  = 9'h004;
	localparam [8:0] S_PTR   = 9'h008;
	localparam [8:0] S_ACKP  = 9'h010;
	localparam [8:0] S_WDAT  = 9'h020;
	localparam [8:0] S_ACKW  = 9'h040;
	localparam [8:0] S_RDAT  = 9'h080;
	localparam [8:0] S_ACKR  = 9'h100;

	reg  [8:0] state_q;
	reg  [8:0] state_d;
	reg  [3:0] cnt_q;
	reg  [3:0] cnt_d;
	reg  [7:0] shift_q;
	reg  [7:0] shift_d;
	reg  [7:0] ptr_q;
	reg  [7:0] ptr_d;
	reg        drive_q;
	reg        drive_d;
	reg        rw_q;
	reg        rw_d;
	reg        wr_stb_q;
	reg        wr_stb_d;
	reg        rd_stb_q;
	reg        rd_stb_d;
	reg  [7:0] wr_data_q;
	reg  [7:0] wr_data_d;
	reg  [7:0] wr_addr_q;
	reg  [7:0] wr_addr_d;
	reg        scl_q;
	reg        sda_q;
	reg  [7:0] beh_q;
	reg  [7:0] rsa_q;
	reg  [7:0] rsb_q;
	reg  [7:0] rsc_q;
	reg  [7:0] msk_q;
	reg  [5:0] stat_q;
	reg  [5:0] pend_q;
	reg  [7:0] rd_data;

	wire       scl_rise;
	wire       scl_fall;
	wire       bus_start;
	wire       bus_stop;
	wire [4:0] wr_sel;
	wire [4:0] rd_sel;
	wire [5:0] stat;
	wire [5:0] masks;
	wire       irq;

	// One-hot select of the bank register at an address.
	function [4:0] reg_sel;
		input [7:0] addr;
		begin
			case (addr)
				`ADDR_OUT_BEHAV: reg_sel = 5'h01;
				`ADDR_RSVD_A:    reg_sel = 5'h02;
				`ADDR_RSVD_B:    reg_sel = 5'h04;
				`ADDR_RSVD_C:    reg_sel = 5'h08;
				`ADDR_IRQ_MASKS: reg_sel = 5'h10;
				default:         reg_sel = 5'h00;
			endcase
		end
	endfunction

	// Bus events from the previous and present line levels.
	assign scl_rise  = scl_in & ~scl_q;
	assign scl_fall  = ~scl_in & scl_q;
	assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
	assign bus_stop  = scl_in & scl_q & ~sda_q & sda_in;

	// The slave only ever pulls sda low; the enable is low while pulling.
	assign sda_out  = 1'b0;
	assign sda_oe_n = ~drive_q;

	// Read data for the present pointer; unmapped addresses read as zero.
	always @* begin
		case (rd_sel)
			5'h01:   rd_data = beh_q;
			5'h02:   rd_data = rsa_q;
			5'h04:   rd_data = rsb_q;
			5'h08:   rd_data = rsc_q;
			5'h10:   rd_data = msk_q;
			default: rd_data = `READ_UNMAPPED;
		endcase
	end
	assign rd_sel = reg_sel(ptr_q);

	// Serial slave: bits are taken on scl rise, sda changes on scl fall.
	always @* begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		shift_d   = shift_q;
		ptr_d     = ptr_q;
		drive_d   = drive_q;
		rw_d      = rw_q;
		wr_stb_d  = 1'b0;
		rd_stb_d  = 1'b0;
		wr_data_d = wr_data_q;
		wr_addr_d = wr_addr_q;
		if (bus_start) begin
			state_d = S_ADDR;
			cnt_d   = 4'h0;
			drive_d = 1'b0;
		end else if (bus_stop) begin
			state_d = S_IDLE;
			drive_d = 1'b0;
		end else begin
			case (state_q)
				S_ADDR, S_PTR, S_WDAT: begin
					if (scl_rise && cnt_q != 4'h8) begin
						shift_d = {shift_q[6:0], sda_in};
						cnt_d   = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						drive_d = 1'b1;
						if (state_q == S_ADDR) begin
							rw_d = shift_q[0];
							if (shift_q[7:1] == DEV_ADDR) begin
								state_d = S_ACKA;
							end else begin
								state_d = S_IDLE;
								drive_d = 1'b0;
							end
						end else if (state_q == S_PTR) begin
							ptr_d   = shift_q;
							state_d = S_ACKP;
						end else begin
							wr_stb_d  = 1'b1;
							wr_data_d = shift_q;
							wr_addr_d = ptr_q;
							state_d   = S_ACKW;
						end
					end
				end
				S_ACKA, S_ACKP, S_ACKW: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (state_q == S_ACKA && rw_q) begin
							shift_d  = rd_data;
							rd_stb_d = 1'b1;
							drive_d  = ~rd_data[7];
							state_d  = S_RDAT;
						end else begin
							drive_d = 1'b0;
							if (state_q == S_ACKW)
								ptr_d = ptr_q + 8'h01;
							state_d = (state_q == S_ACKA) ? S_PTR : S_WDAT;
						end
					end
				end
				S_RDAT: begin
					if (scl_fall) begin
						if (cnt_q == 4'h7) begin
							drive_d = 1'b0;
							state_d = S_ACKR;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							drive_d = ~shift_q[6];
							cnt_d   = cnt_q + 4'h1;
						end
					end
				end
				S_ACKR: begin
					// A master acknowledge asks for the next byte.
					if (scl_rise) begin
						if (sda_in)
							state_d = S_IDLE;
						else
							ptr_d = ptr_q + 8'h01;
					end else if (scl_fall) begin
						cnt_d    = 4'h0;
						shift_d  = rd_data;
						rd_stb_d = 1'b1;
						drive_d  = ~rd_data[7];
						state_d  = S_RDAT;
					end
				end
				S_IDLE: begin
					drive_d = 1'b0;
				end
				default: begin
					state_d = S_IDLE;
					drive_d = 1'b0;
				end
			endcase
		end
	end

	// Slave state and line history.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q   <= S_IDLE;
			cnt_q     <= 4'h0;
			shift_q   <= 8'h00;
			ptr_q     <= 8'h00;
			drive_q   <= 1'b0;
			rw_q      <= 1'b0;
			wr_stb_q  <= 1'b0;
			rd_stb_q  <= 1'b0;
			wr_data_q <= 8'h00;
			wr_addr_q <= 8'h00;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			shift_q   <= shift_d;
			ptr_q     <= ptr_d;
			drive_q   <= drive_d;
			rw_q      <= rw_d;
			wr_stb_q  <= wr_stb_d;
			rd_stb_q  <= rd_stb_d;
			wr_data_q <= wr_data_d;
			wr_addr_q <= wr_addr_d;
			scl_q     <= scl_in;
			sda_q     <= sda_in;
		end
	end

	assign wr_sel = reg_sel(wr_addr_q);

	// Bank registers; reserved ones simply hold what the host writes.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			beh_q <= `RST_OUT_BEHAV;
			rsa_q <= `RST_RSVD_A;
			rsb_q <= `RST_RSVD_B;
			rsc_q <= `RST_RSVD_C;
			msk_q <= `RST_IRQ_MASKS;
		end else if (wr_stb_q) begin
			if (wr_sel[0])
				beh_q <= wr_data_q;
			if (wr_sel[1])
				rsa_q <= wr_data_q;
			if (wr_sel[2])
				rsb_q <= wr_data_q;
			if (wr_sel[3])
				rsc_q <= wr_data_q;
			if (wr_sel[4])
				msk_q <= wr_data_q;
		end
	end

	// Status vector, highest bit pairs with the highest mask bit.
	assign stat  = {nonstd_vsync_status, trick_play_status,
		interlace_status, tape_source_status, insertion_status,
		fast_blank_status};
	assign masks = msk_q[`MASK_LSB+`NUM_DETECT-1:`MASK_LSB];

	// Each edge of an unmasked status latches a pending bit; reading the
	// mask register clears them, but a new edge in that cycle wins.
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_DETECT; gi = gi + 1) begin : g_det
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					stat_q[gi] <= 1'b0;
					pend_q[gi] <= 1'b0;
				end else begin
					stat_q[gi] <= stat[gi];
					pend_q[gi] <= ((stat[gi] ^ stat_q[gi]) &
						~masks[gi]) |
						(pend_q[gi] & ~(rd_stb_q & rd_sel[4]));
				end
			end
		end
	endgenerate

	// Bits 7 to 2 map to sync, trick, interlace, tape, insertion, fast.
	assign irq = |pend_q;

	// Lock pad carries the interrupt or its other function.
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			pll_locked_pad <= 1'b0;
		else
			pll_locked_pad <= lock_pad_irq_enable ? irq : lock_pad_func;
	end

	// Output path control, steered by the behaviour register.
	vout_behaviour u_behav (
		.clk              (clk),
		.resetn           (resetn),
		.reissue_en       (beh_q[`BIT_REISSUE_EN]),
		.clk_track_sel    (beh_q[`BIT_CLK_TRACK]),
		.novid_blank_sel  (beh_q[`BIT_NOVID_BLANK]),
		.trans_blank_sel  (beh_q[`BIT_TRANS_BLANK]),
		.gain             ({beh_q[`GAIN_MSB_HI:`GAIN_MSB_LO],
			cb_gain_lsb}),
		.horiz_locked     (horiz_locked),
		.vert_locked      (vert_locked),
		.vbi_active       (vbi_active),
		.cb_in            (cb_in),
		.out_clk_free_run (out_clk_free_run),
		.out_clk_track    (out_clk_track),
		.out_blank        (out_blank),
		.fifo_read_en     (fifo_read_en),
		.vbi_capture_en   (vbi_capture_en),
		.cb_out           (cb_out)
	);

endmodule // vout_ctrl_regs

`default_nettype wire

// *** verif/vout_ctrl_regs_properties.sv ***
/* Checker of the bank's output pins against lock, blanking and pad state.
   Assumes it is bound into vout_ctrl_regs by the bind at the foot. */
`timescale 1ns/10ps
`default_nettype none
module vout_ctrl_regs_properties (
	input wire logic clk,                 // Clock.
	input wire logic resetn,              // Reset, active low.
	input wire logic horiz_locked,        // Line lock.
	input wire logic vert_locked,         // Field lock.
	input wire logic vbi_active,          // Blanking interval.
	input wire logic lock_pad_irq_enable, // Pad carries interrupt.
	input wire logic lock_pad_func,       // Pad alternate level.
	input wire logic nonstd_vsync_status, // Status.
	input wire logic trick_play_status,   // Status.
	input wire logic interlace_status,    // Status.
	input wire logic tape_source_status,  // Status.
	input wire logic insertion_status,    // Status.
	input wire logic fast_blank_status,   // Status.
	input wire logic pll_locked_pad,      // Pad level.
	input wire logic out_clk_free_run,    // Free-run flag.
	input wire logic out_clk_track,       // Track flag.
	input wire logic out_blank,           // Blank flag.
	input wire logic fifo_read_en,        // FIFO read flag.
	input wire logic vbi_capture_en       // Capture flag.
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [5:0] stat_q;
	logic [3:0] edge_hist_q;
	wire  [5:0] stat = {nonstd_vsync_status, trick_play_status,
		interlace_status, tape_source_status, insertion_status,
		fast_blank_status};
	// Records status edges over the last four cycles.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stat_q      <= 6'h00;
			edge_hist_q <= 4'h0;
		end else begin
			stat_q      <= stat;
			edge_hist_q <= {edge_hist_q[2:0], stat != stat_q};
		end
	end
	// Outputs lag their causes by one cycle, so skip the release edge.
	sequence s_settled;
		$past(resetn);
	endsequence
	sequence s_pad_irq_rise;
		$rose(pll_locked_pad) && $past(lock_pad_irq_enable) &&
			$past(lock_pad_irq_enable, 2);
	endsequence
	property p_free_run;
		s_settled |-> out_clk_free_run ==
			(!out_clk_track && !$past(horiz_locked));
	endproperty
	a_free_run: assert property (p_free_run)
		else $error("free-run flag disagrees with lock and track");
	property p_track_excl;
		out_clk_track |-> !out_clk_free_run;
	endproperty
	a_track_excl: assert property (p_track_excl)
		else $error("tracking clock also marked free-running");
	property p_blank_gate;
		out_blank |-> !out_clk_track;
	endproperty
	a_blank_gate: assert property (p_blank_gate)
		else $error("blanking active while clock tracks");
	property p_fifo_compl;
		s_settled |-> fifo_read_en != out_blank;
	endproperty
	a_fifo_compl: assert property (p_fifo_compl)
		else $error("fifo read and blank not complementary");
	property p_blank_cause;
		out_blank |-> !($past(horiz_locked) && $past(vert_locked));
	endproperty
	a_blank_cause: assert property (p_blank_cause)
		else $error("blanking with full lock");
	property p_vbi;
		vbi_capture_en |-> $past(vbi_active);
	endproperty
	a_vbi: assert property (p_vbi)
		else $error("line capture outside vertical blanking");
	property p_pad_func;
		s_settled ##0 !$past(lock_pad_irq_enable) |->
			pll_locked_pad == $past(lock_pad_func);
	endproperty
	a_pad_func: assert property (p_pad_func)
		else $error("pad does not follow its alternate level");
	property p_irq_cause;
		s_pad_irq_rise |-> edge_hist_q != 4'h0;
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt pad rose without a status edge");
endmodule // vout_ctrl_regs_properties
bind vout_ctrl_regs vout_ctrl_regs_properties chk_u (.clk, .resetn,
	.horiz_locked, .vert_locked, .vbi_active, .lock_pad_irq_enable,
	.lock_pad_func, .nonstd_vsync_status, .trick_play_status,
	.interlace_status, .tape_source_status, .insertion_status,
	.fast_blank_status, .pll_locked_pad, .out_clk_free_run,
	.out_clk_track, .out_blank, .fifo_read_en, .vbi_capture_en);
`default_nettype wire

// *** verif/serial_host_model.sv ***
/* Host on the two-wire bus: register writes and pointer reads.
   Assumes the bench resolves sda with a pull-up from both parties. */
`timescale 1ns/10ps
`default_nettype none
module serial_host_model #(
	parameter [6:0] SLAVE = 7'h44 // Slave address, arbitrary value.
) (
	input  wire logic clk,      // System clock.
	input  wire logic sda_line, // Resolved data line.
	output var  logic scl,      // Serial clock.
	output var  logic sda_rel,  // High releases data, low pulls it.
	output var  logic nack_seen // Set when a byte goes unacknowledged.
);
	initial begin
		scl       = 1'b1;
		sda_rel   = 1'b1;
		nack_seen = 1'b0;
	end
	// Each phase lasts four clocks, twice the slave's minimum.
	task automatic tick;
		repeat (4) @(posedge clk);
	endtask
	// Data moves only while scl is low, a clear phase from each edge.
	task automatic put_bit(input logic b);
		sda_rel <= b;
		tick();
		scl <= 1'b1;
		tick();
		scl <= 1'b0;
		tick();
	endtask
	task automatic get_bit(output logic b);
		sda_rel <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		b = sda_line;
		scl <= 1'b0;
		tick();
	endtask
	// Start from idle or repeated start: sda falls while scl is high.
	task automatic start;
		sda_rel <= 1'b1;
		tick();
		scl <= 1'b1;
		tick();
		sda_rel <= 1'b0;
		tick();
		scl <= 1'b0;
		tick();
	endtask
	task automatic stop;
		sda_rel <= 1'b0;
		tick();
		scl <= 1'b1;
		tick();
		sda_rel <= 1'b1;
		tick();
	endtask
	task automatic put_byte(input logic [7:0] v);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		get_bit(a);
		if (a) nack_seen <= 1'b1;
	endtask
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		start();
		put_byte({SLAVE, 1'b0});
		put_byte(a);
		put_byte(d);
		stop();
	endtask
	// Sets the pointer, then reads one byte and ends with a NACK.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		start();
		put_byte({SLAVE, 1'b0});
		put_byte(a);
		start();
		put_byte({SLAVE, 1'b1});
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(1'b1);
		stop();
	endtask
endmodule // serial_host_model
`default_nettype wire

// *** verif/vout_ctrl_regs_tb.sv ***
/* Bench for the output behaviour and detection mask register bank.
   Assumes the host model drives the bus and sda has a pull-up. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
$display("unexpected at %0t got %h expected %h", $time, g, e); \
num_errors++; end end
module vout_ctrl_regs_tb;
	logic        clk, resetn, hl, vl, vbi, pad_en, pad_func;
	logic        scl, sda_rel, nack_seen;
	wire         sda_out, sda_oe_n, pad, free_run, track, blank;
	wire         fifo_rd, vbi_cap;
	logic [1:0]  lsb;
	logic [5:0]  stat;
	logic [7:0]  cb_in, rd;
	wire  [7:0]  cb_out;
	wire         sda_line = sda_rel & (sda_oe_n | sda_out);
	int          num_errors = 0, samples_checked = 0, p;
	logic [7:0]  rst_val [6] = '{8'h2F, 8'h55, 8'h55, 8'h35, 8'hFC, 8'h00};
	logic [11:0] tbl [9] = '{12'h400, 12'h001, 12'h103, 12'h108, 12'h20A,
		12'h201, 12'h700, 12'h708, 12'h30C};
	logic [17:0] cbt [4] = '{18'h03F40, 18'h00040, 18'h022C0, 18'h03F81};
	vout_ctrl_regs #(.DEV_ADDR(7'h44)) dut_u (
		.clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .cb_gain_lsb(lsb),
		.lock_pad_irq_enable(pad_en), .lock_pad_func(pad_func),
		.pll_locked_pad(pad), .nonstd_vsync_status(stat[5]),
		.trick_play_status(stat[4]), .interlace_status(stat[3]),
		.tape_source_status(stat[2]), .insertion_status(stat[1]),
		.fast_blank_status(stat[0]), .horiz_locked(hl), .vert_locked(vl),
		.vbi_active(vbi), .cb_in(cb_in), .out_clk_free_run(free_run),
		.out_clk_track(track), .out_blank(blank), .fifo_read_en(fifo_rd),
		.vbi_capture_en(vbi_cap), .cb_out(cb_out));
	serial_host_model #(.SLAVE(7'h44)) host_u (.clk(clk),
		.sda_line(sda_line), .scl(scl), .sda_rel(sda_rel),
		.nack_seen(nack_seen));
	// Clock of 25 ns period.
	always #12.5 clk = ~clk;
	task automatic settle;
		repeat (4) @(posedge clk);
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Cuts a hung run short and reports it as a mismatch.
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		close_out();
	end
	// Main sequence: reset values, output modes, gain, masks, pad.
	initial begin
		{clk, resetn, hl, vl, vbi, pad_en, pad_func, lsb, stat, cb_in} = '0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			host_u.read_reg(8'h38 + i[7:0], rd);
			`CHK(rd, rst_val[i])
		end
		host_u.write_reg(8'h39, 8'h55);
		host_u.write_reg(8'h3A, 8'h55);
		host_u.write_reg(8'h3B, 8'h35);
		host_u.read_reg(8'h3A, rd);
		`CHK(rd, 8'h55)
		foreach (tbl[i]) begin
			host_u.write_reg(8'h38, tbl[i][11:4]);
			hl <= tbl[i][3];
			vl <= tbl[i][2];
			settle();
			`CHK(blank, tbl[i][1])
			`CHK(fifo_rd, !tbl[i][1])
			`CHK(free_run, tbl[i][0])
			`CHK(track, tbl[i][10])
		end
		host_u.write_reg(8'h38, 8'h80);
		vbi <= 1'b1;
		settle();
		`CHK(vbi_cap, 1'b1)
		vbi <= 1'b0;
		settle();
		`CHK(vbi_cap, 1'b0)
		// With pass-through off, blanking lines must not be captured.
		host_u.write_reg(8'h38, 8'h00);
		vbi <= 1'b1;
		settle();
		`CHK(vbi_cap, 1'b0)
		vbi <= 1'b0;
		foreach (cbt[i]) begin
			host_u.write_reg(8'h38, cbt[i][17:10]);
			lsb   <= cbt[i][9:8];
			cb_in <= cbt[i][7:0];
			settle();
			p = $signed(cb_in) * (int'({cbt[i][13:10], cbt[i][9:8]}) + 1);
			`CHK(cb_out, p[13:6])
		end
		pad_en <= 1'b1;
		stat   <= 6'h3F;
		settle();
		`CHK(pad, 1'b0)
		host_u.write_reg(8'h3C, 8'h00);
		for (int i = 0; i < 6; i++) begin
			stat[i] <= ~stat[i];
			settle();
			`CHK(pad, 1'b1)
			host_u.read_reg(8'h3C, rd);
			`CHK(rd, 8'h00)
			settle();
			`CHK(pad, 1'b0)
			host_u.write_reg(8'h3C, 8'h04 << i);
			stat[i] <= ~stat[i];
			settle();
			`CHK(pad, 1'b0)
			host_u.write_reg(8'h3C, 8'h00);
		end
		pad_en   <= 1'b0;
		pad_func <= 1'b1;
		settle();
		`CHK(pad, 1'b1)
		`CHK(nack_seen, 1'b0)
		close_out();
	end
endmodule // vout_ctrl_regs_tb
`default_nettype wire
